// file: design/mmap_pkg.sv
`default_nettype none
package mmap_pkg;
  localparam logic [7:0]  SFR_STATUS_ADDR   = 8'hD0;
  localparam logic [7:0]  SFR_STACK_ADDR    = 8'h81;
  localparam logic [7:0]  SFR_DPL_ADDR      = 8'h82;
  localparam logic [7:0]  SFR_DPH_ADDR      = 8'h83;
  localparam logic [7:0]  SFR_PAGE_ADDR     = 8'hAA;
  localparam logic [7:0]  SFR_ACC_ADDR      = 8'hE0;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam logic [7:0]  STACK_RESET       = 8'h07;
  localparam logic [7:0]  DATA_POINTER_BYTE_RESET   = 8'h00;
  localparam logic [7:0]  ACC_RESET         = 8'h00;
  localparam logic [3:0]  PAGE_RESET        = 4'h0;
  localparam int          CARRY_BIT         = 7;
  localparam int          NIBBLE_BIT        = 6;
  localparam int          USER0_BIT         = 5;
  localparam int          BANK_HI_BIT       = 4;
  localparam int          BANK_LO_BIT       = 3;
  localparam int          OVERFLOW_BIT      = 2;
  localparam int          USER1_BIT         = 1;
  localparam int          PARITY_BIT        = 0;
  localparam logic [7:0]  DIRECT_LIMIT      = 8'h7F;
  localparam logic [7:0]  BIT_AREA_BASE     = 8'h20;
  localparam logic [7:0]  MUL_LIMIT         = 8'hFF;
  localparam logic [15:0] FLASH_END_LARGE   = 16'hFBFF;
  localparam logic [15:0] FLASH_END_SMALL   = 16'h7FFF;
  localparam int          XRAM_BYTES        = 4096;
  localparam int          IRAM_BYTES        = 256;

  typedef enum logic [2:0] {
    MMAP_ALU_NONE,
    MMAP_ALU_ADD,
    MMAP_ALU_ADDC,
    MMAP_ALU_SUBB,
    MMAP_ALU_MUL,
    MMAP_ALU_DIV,
    MMAP_ALU_OTHER
  } mmap_alu_t;
endpackage
`default_nettype wire

// file: design/mmap_iram.sv
`timescale 1ns/100ps
`default_nettype none
module mmap_iram
  import mmap_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input  wire logic       clk,    // core clock
  input  wire logic [7:0] waddr,  // write address
  input  wire logic [7:0] wdata,  // write data
  input  wire logic       we,     // write strobe
  input  wire logic [7:0] raddr,  // read address
  output logic      [7:0] rdata,  // registered read data
  input  wire logic [7:0] r0_addr,// bank word 0 address
  input  wire logic [7:0] r1_addr,// bank word 1 address
  output logic      [7:0] r0_data,// combinational bank word 0
  output logic      [7:0] r1_data // combinational bank word 1
);
  logic [7:0] mem [DEPTH];

  // no reset on the array: contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

  assign r0_data = mem[r0_addr];
  assign r1_data = mem[r1_addr];
endmodule
`default_nettype wire

// file: design/mmap_xram.sv
`timescale 1ns/100ps
`default_nettype none
module mmap_xram
  import mmap_pkg::*;
#(
  parameter int DEPTH = XRAM_BYTES,
  parameter int AW    = 12
) (
  input  wire logic          clk,   // core clock
  input  wire logic [AW-1:0] addr,  // byte address
  input  wire logic [7:0]    wdata, // write data
  input  wire logic          we,    // write strobe
  output logic      [7:0]    rdata  // registered read data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// file: design/mmap_core_mem.sv
// Function
// RL1: carry set on carry or borrow
// RL2: nibble carry set on nibble carry/borrow
// RL3: bank field picks eight-byte register bank
// RL4: overflow on signed, mul, divide-by-zero
// RL5: parity bit shows odd accumulator ones
// RL6: two user flags plain storage
// RL7: status word at 0xD0, bit/byte, resets zero
// RL8: 256 bytes RAM, low half both modes
// RL9: direct high hits registers, indirect RAM
// RL10: bit area 0x20-0x2F as 128 bits
// RL11: operand type picks bit or byte
// RL12: one bank active, chosen by field
// RL13: indirect address from word 0 or 1
// RL14: push writes pointer+1, pointer resets 0x07
// RL15: flash contiguous, lock byte last, rest reserved
// RL16: code move reads flash, external move selectable
// RL17: 4096 xram bytes via pointer or page
// RL18: program and data spaces kept separate
// RL19: page register upper bits read zero
// RL20: parity combinational from accumulator
`timescale 1ns/100ps
`default_nettype none
module mmap_core_mem
  import mmap_pkg::*;
#(
  parameter logic LARGE_FLASH = 1'b1
) (
  input  wire logic        SYS_CLK,      // core clock
  input  wire logic        RST,          // async reset, high
  input  wire logic        DIR_RD,       // direct byte/bit read request
  input  wire logic        DIR_WR,       // direct byte/bit write request
  input  wire logic        IND_RD,       // indirect read via working register
  input  wire logic        IND_WR,       // indirect write via working register
  input  wire logic        BIT_OP,       // operand is a bit, not a byte
  input  wire logic [7:0]  DIR_ADDR,     // direct address or bit address
  input  wire logic        IND_SEL,      // 0: working_register_zero, 1: one
  input  wire logic [7:0]  WR_DATA,      // byte write data
  input  wire logic        WR_BIT,       // bit write value
  input  wire logic        BANK_REG_RD,  // read working register of active bank
  input  wire logic [2:0]  BANK_REG_NUM, // working register number
  input  wire logic        PUSH,         // push WR_DATA onto stack
  input  wire logic        POP,          // pop top of stack
  input  wire logic [2:0]  ALU_OP,       // arithmetic class, mmap_alu_t
  input  wire logic        ALU_CARRY,    // carry or borrow out
  input  wire logic        ALU_NIBBLE,   // nibble carry or borrow
  input  wire logic        ALU_SOVF,     // signed overflow
  input  wire logic [15:0] ALU_PRODUCT,  // multiply result
  input  wire logic        ALU_DIV_ZERO, // divisor was zero
  input  wire logic [7:0]  ACC_IN,       // new accumulator value
  input  wire logic        ACC_WE,       // accumulator load
  input  wire logic        XMOV_RD,      // external move read
  input  wire logic        XMOV_WR,      // external move write
  input  wire logic        XMOV_PTR16,   // 1: data pointer form, 0: page form
  input  wire logic        XMOV_TO_FLASH,// redirect external writes to flash
  input  wire logic        CMOV_RD,      // code move read
  input  wire logic [15:0] CODE_ADDR,    // code move address
  output logic      [7:0]  RD_DATA,      // read data, one cycle after request
  output logic             RD_BIT,       // bit read data, with RD_DATA
  output logic             RD_VALID,     // read data valid pulse
  output logic      [7:0]  STATUS_WORD,  // program_status_word view
  output logic      [7:0]  ACC,          // accumulator
  output logic      [7:0]  STACK_PTR,    // stack pointer
  output logic      [15:0] DATA_PTR,     // data pointer
  output logic      [3:0]  XRAM_PAGE,    // page select
  output logic      [15:0] FLASH_ADDR,   // program flash address
  output logic             FLASH_RD,     // program flash read strobe
  output logic             FLASH_WR,     // flash write strobe from external move
  output logic      [7:0]  FLASH_WDATA,  // flash write data
  output logic             FLASH_RESERVED// address above lock byte
);
  logic [7:0]  status_store;
  logic [7:0]  iram_waddr;
  logic [7:0]  iram_wdata;
  logic        iram_we;
  logic [7:0]  iram_raddr;
  logic [7:0]  iram_rdata;
  logic [7:0]  r0_data;
  logic [7:0]  r1_data;
  logic [7:0]  bank_base;
  logic [7:0]  ind_addr;
  logic [7:0]  bit_byte;
  logic [2:0]  bit_pos;
  logic        dir_is_sfr;
  logic        bit_in_ram;
  logic [7:0]  sfr_rdata;
  logic [7:0]  sfr_q;
  logic        src_sfr;
  logic        src_xram;
  logic        bit_q;
  logic [2:0]  bit_pos_q;
  logic [11:0] xram_addr;
  logic [7:0]  xram_rdata;
  logic        xram_we;
  logic        parity;
  logic [15:0] flash_end;
  logic [7:0]  sfr_wval;
  logic        sfr_bit_wr;

  assign parity = ^ACC; // [RL5] [RL20]
  assign STATUS_WORD = {status_store[7:1], parity}; // [RL7]
  assign flash_end = LARGE_FLASH ? FLASH_END_LARGE : FLASH_END_SMALL;

  assign bank_base = {3'b000, status_store[BANK_HI_BIT:BANK_LO_BIT], 3'b000}; // [RL3] [RL12]
  assign ind_addr  = IND_SEL ? r1_data : r0_data; // [RL13]
  assign dir_is_sfr = DIR_ADDR > DIRECT_LIMIT; // [RL9]
  // bit addresses above 0x7F are register bits on byte addresses ending in 0 or 8
  assign bit_in_ram = DIR_ADDR <= DIRECT_LIMIT;
  assign bit_byte = bit_in_ram ? (BIT_AREA_BASE + {3'b000, DIR_ADDR[7:3]}) : {DIR_ADDR[7:3], 3'b000}; // [RL10]
  assign bit_pos  = DIR_ADDR[2:0];

  // sfr read mux
  always_comb begin
    sfr_rdata = 8'h00;
    case (BIT_OP ? bit_byte : DIR_ADDR)
      SFR_STATUS_ADDR: sfr_rdata = STATUS_WORD;
      SFR_STACK_ADDR:  sfr_rdata = STACK_PTR;
      SFR_DPL_ADDR:    sfr_rdata = DATA_PTR[7:0];
      SFR_DPH_ADDR:    sfr_rdata = DATA_PTR[15:8];
      SFR_PAGE_ADDR:   sfr_rdata = {4'h0, XRAM_PAGE}; // [RL19]
      SFR_ACC_ADDR:    sfr_rdata = ACC;
      default:         sfr_rdata = 8'h00;
    endcase
  end

  // bit writes are read-modify-write of the addressed register
  always_comb begin
    sfr_wval = sfr_rdata;
    if (BIT_OP) begin // [RL11]
      sfr_wval[bit_pos] = WR_BIT;
    end else begin
      sfr_wval = WR_DATA;
    end
  end
  assign sfr_bit_wr = DIR_WR && (BIT_OP ? !bit_in_ram : dir_is_sfr); // [RL9]

  // ram port: push, indirect and direct low half
  always_comb begin
    iram_we    = 1'b0;
    iram_waddr = 8'h00;
    iram_wdata = WR_DATA;
    iram_raddr = 8'h00;
    if (PUSH) begin
      iram_we    = 1'b1;
      iram_waddr = STACK_PTR + 8'h01; // [RL14]
    end else if (IND_WR) begin
      iram_we    = 1'b1;
      iram_waddr = ind_addr; // [RL8] [RL9]
    end else if (DIR_WR && BIT_OP && bit_in_ram) begin
      iram_we    = 1'b1;
      iram_waddr = bit_byte; // [RL10]
      iram_wdata = iram_rdata;
      iram_wdata[bit_pos] = WR_BIT;
    end else if (DIR_WR && !BIT_OP && !dir_is_sfr) begin
      iram_we    = 1'b1;
      iram_waddr = DIR_ADDR; // [RL8]
    end
    if (POP) begin
      iram_raddr = STACK_PTR;
    end else if (IND_RD) begin
      iram_raddr = ind_addr;
    end else if (BANK_REG_RD) begin
      iram_raddr = bank_base | {5'b00000, BANK_REG_NUM}; // [RL12]
    end else begin
      iram_raddr = BIT_OP ? bit_byte : DIR_ADDR;
    end
  end

  mmap_iram #(
    .DEPTH(IRAM_BYTES)
  ) u_iram (
    .clk     (SYS_CLK),
    .waddr   (iram_waddr),
    .wdata   (iram_wdata),
    .we      (iram_we),
    .raddr   (iram_raddr),
    .rdata   (iram_rdata),
    .r0_addr (bank_base),
    .r1_addr (bank_base | 8'h01),
    .r0_data (r0_data),
    .r1_data (r1_data)
  );

  // page form: page register high four bits, working register low byte
  assign xram_addr = XMOV_PTR16 ? DATA_PTR[11:0] : {XRAM_PAGE, ind_addr}; // [RL17] [RL19]
  assign xram_we   = XMOV_WR && !XMOV_TO_FLASH; // [RL16]

  mmap_xram #(
    .DEPTH(XRAM_BYTES),
    .AW   (12)
  ) u_xram (
    .clk   (SYS_CLK),
    .addr  (xram_addr),
    .wdata (WR_DATA),
    .we    (xram_we),
    .rdata (xram_rdata)
  );

  // flash strobes: code move always reads program space
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FLASH_RD       <= 1'b0;
      FLASH_WR       <= 1'b0;
      FLASH_ADDR     <= 16'h0000;
      FLASH_WDATA    <= 8'h00;
      FLASH_RESERVED <= 1'b0;
    end else begin
      FLASH_RD <= CMOV_RD; // [RL16] [RL18]
      FLASH_WR <= XMOV_WR && XMOV_TO_FLASH; // [RL16]
      if (CMOV_RD || (XMOV_WR && XMOV_TO_FLASH)) begin
        FLASH_ADDR     <= CMOV_RD ? CODE_ADDR : DATA_PTR; // [RL18]
        FLASH_WDATA    <= WR_DATA;
        FLASH_RESERVED <= (CMOV_RD ? CODE_ADDR : DATA_PTR) > flash_end; // [RL15]
      end
    end
  end

  // read steering registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RD_VALID  <= 1'b0;
      src_sfr   <= 1'b0;
      src_xram  <= 1'b0;
      bit_q     <= 1'b0;
      bit_pos_q <= 3'h0;
      sfr_q     <= 8'h00;
    end else begin
      RD_VALID  <= DIR_RD || IND_RD || POP || BANK_REG_RD || XMOV_RD;
      src_xram  <= XMOV_RD;
      src_sfr   <= DIR_RD && (BIT_OP ? !bit_in_ram : dir_is_sfr); // [RL9]
      bit_q     <= BIT_OP; // [RL11]
      bit_pos_q <= bit_pos;
      sfr_q     <= sfr_rdata;
    end
  end

  always_comb begin
    RD_DATA = src_xram ? xram_rdata : (src_sfr ? sfr_q : iram_rdata);
    RD_BIT  = bit_q ? RD_DATA[bit_pos_q] : 1'b0;
  end

  // status word: software writes first, arithmetic results override flags
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status_store <= STATUS_RESET; // [RL7]
    end else begin
      if (sfr_bit_wr && ((BIT_OP ? bit_byte : DIR_ADDR) == SFR_STATUS_ADDR)) begin
        status_store <= {sfr_wval[7:1], 1'b0}; // [RL6] [RL7]
      end
      case (mmap_alu_t'(ALU_OP))
        MMAP_ALU_ADD, MMAP_ALU_ADDC, MMAP_ALU_SUBB: begin
          status_store[CARRY_BIT]    <= ALU_CARRY; // [RL1]
          status_store[NIBBLE_BIT]   <= ALU_NIBBLE; // [RL2]
          status_store[OVERFLOW_BIT] <= ALU_SOVF; // [RL4]
        end
        MMAP_ALU_MUL: begin
          status_store[CARRY_BIT]    <= 1'b0; // [RL1]
          status_store[OVERFLOW_BIT] <= ALU_PRODUCT > {8'h00, MUL_LIMIT}; // [RL4]
        end
        MMAP_ALU_DIV: begin
          status_store[CARRY_BIT]    <= 1'b0; // [RL1]
          status_store[OVERFLOW_BIT] <= ALU_DIV_ZERO; // [RL4]
        end
        MMAP_ALU_OTHER: begin
          status_store[CARRY_BIT]  <= ALU_CARRY; // [RL1]
          status_store[NIBBLE_BIT] <= 1'b0; // [RL2]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ACC <= ACC_RESET;
    end else if (ACC_WE) begin
      ACC <= ACC_IN;
    end else if (sfr_bit_wr && ((BIT_OP ? bit_byte : DIR_ADDR) == SFR_ACC_ADDR)) begin
      ACC <= sfr_wval;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      STACK_PTR <= STACK_RESET; // [RL14]
    end else if (PUSH) begin
      STACK_PTR <= STACK_PTR + 8'h01; // [RL14]
    end else if (POP) begin
      STACK_PTR <= STACK_PTR - 8'h01;
    end else if (sfr_bit_wr && !BIT_OP && DIR_ADDR == SFR_STACK_ADDR) begin
      STACK_PTR <= WR_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DATA_PTR  <= {DATA_POINTER_BYTE_RESET, DATA_POINTER_BYTE_RESET};
      XRAM_PAGE <= PAGE_RESET;
    end else if (sfr_bit_wr && !BIT_OP) begin
      if (DIR_ADDR == SFR_DPL_ADDR) begin
        DATA_PTR[7:0] <= WR_DATA;
      end
      if (DIR_ADDR == SFR_DPH_ADDR) begin
        DATA_PTR[15:8] <= WR_DATA;
      end
      if (DIR_ADDR == SFR_PAGE_ADDR) begin
        XRAM_PAGE <= WR_DATA[3:0]; // [RL19]
      end
    end
  end

  a_push_pointer: assert property (@(posedge SYS_CLK) disable iff (RST)
    PUSH |=> STACK_PTR == $past(STACK_PTR) + 8'h01) else $error("push pointer step wrong"); // [RL14]
  a_parity_track: assert property (@(posedge SYS_CLK) disable iff (RST)
    ACC_WE |=> STATUS_WORD[PARITY_BIT] == ^$past(ACC_IN)) else $error("parity mismatch"); // [RL5]
  a_carry_add: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ALU_OP == MMAP_ALU_ADD) |=> STATUS_WORD[CARRY_BIT] == $past(ALU_CARRY)) else $error("carry wrong"); // [RL1]
  a_nibble_sub: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ALU_OP == MMAP_ALU_SUBB) |=> STATUS_WORD[NIBBLE_BIT] == $past(ALU_NIBBLE)) else $error("nibble wrong"); // [RL2]
  a_mul_ovf: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ALU_OP == MMAP_ALU_MUL && ALU_PRODUCT > 16'h00FF) |=> STATUS_WORD[OVERFLOW_BIT]) else $error("mul ovf"); // [RL4]
  a_div_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ALU_OP == MMAP_ALU_DIV) |=> STATUS_WORD[OVERFLOW_BIT] == $past(ALU_DIV_ZERO)) else $error("div ovf"); // [RL4]
  a_page_high: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DIR_RD && !BIT_OP && DIR_ADDR == 8'hAA) |=> RD_VALID && RD_DATA[7:4] == 4'h0) else $error("page high"); // [RL19]
  a_flash_route: assert property (@(posedge SYS_CLK) disable iff (RST)
    (XMOV_WR && !XMOV_TO_FLASH && !CMOV_RD) |=> !FLASH_WR) else $error("xram write hit flash"); // [RL16]
  a_bank_base: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BANK_REG_RD && !POP && !IND_RD) |->
      iram_raddr == {3'b000, STATUS_WORD[BANK_HI_BIT:BANK_LO_BIT], BANK_REG_NUM}) else $error("bank base wrong"); // [RL3]
endmodule
`default_nettype wire

// file: testbench/mmap_exec_model.sv
`timescale 1ns/100ps
`default_nettype none
module mmap_exec_model
  import mmap_pkg::*;
(
  input  wire logic sys_clk,       // core clock
  output logic      dir_rd,        // req
  output logic      dir_wr,        // req
  output logic      ind_rd,        // req
  output logic      ind_wr,        // req
  output logic      bit_op,        // bit operand
  output logic [7:0] dir_addr,     // address
  output logic      ind_sel,       // index reg
  output logic [7:0] wr_data,      // data
  output logic      wr_bit,        // bit data
  output logic      bank_reg_rd,   // req
  output logic [2:0] bank_reg_num, // reg number
  output logic      push,          // req
  output logic      pop,           // req
  output logic [2:0] alu_op,       // alu class
  output logic      alu_carry,     // carry
  output logic      alu_nibble,    // nibble carry
  output logic      alu_sovf,      // overflow
  output logic [15:0] alu_product, // product
  output logic      alu_div_zero,  // zero divisor
  output logic [7:0] acc_in,       // acc value
  output logic      acc_we,        // req
  output logic      xmov_rd,       // req
  output logic      xmov_wr,       // req
  output logic      xmov_ptr16,    // pointer form
  output logic      xmov_to_flash, // flash redirect
  output logic      cmov_rd,       // req
  output logic [15:0] code_addr    // code address
);
  // every request lasts exactly one taken edge, then drops
  task automatic go();
    @(posedge sys_clk);
    #2;
    {dir_rd, dir_wr, ind_rd, ind_wr, bank_reg_rd, push, pop, acc_we, xmov_rd, xmov_wr, cmov_rd} = '0;
    alu_op = MMAP_ALU_NONE;
    // a released data bus does not keep its last value
    wr_data = ~wr_data;
  endtask
  task automatic dir(input logic r, input logic w, input logic b, input logic [7:0] a, input logic [7:0] d,
                     input logic v);
    {dir_rd, dir_wr, bit_op, dir_addr, wr_data, wr_bit} = {r, w, b, a, d, v};
    go();
  endtask
  task automatic ind(input logic r, input logic w, input logic s, input logic [7:0] d);
    {ind_rd, ind_wr, ind_sel, wr_data} = {r, w, s, d};
    go();
  endtask
  task automatic breg(input logic [2:0] n);
    {bank_reg_rd, bank_reg_num} = {1'b1, n};
    go();
  endtask
  task automatic stk(input logic u, input logic o, input logic [7:0] d);
    {push, pop, wr_data} = {u, o, d};
    go();
  endtask
  task automatic alu(input logic [2:0] op, input logic [3:0] f, input logic [15:0] p);
    {alu_op, alu_carry, alu_nibble, alu_sovf, alu_div_zero, alu_product} = {op, f, p};
    go();
  endtask
  task automatic acc(input logic [7:0] v);
    {acc_we, acc_in} = {1'b1, v};
    go();
  endtask
  task automatic xmov(input logic r, input logic w, input logic p, input logic f, input logic [7:0] d);
    {xmov_rd, xmov_wr, xmov_ptr16, xmov_to_flash, wr_data} = {r, w, p, f, d};
    go();
  endtask
  task automatic cmov(input logic [15:0] a);
    {cmov_rd, code_addr} = {1'b1, a};
    go();
  endtask
  initial begin
    {dir_rd, dir_wr, ind_rd, ind_wr, bit_op, dir_addr, ind_sel, wr_data, wr_bit, bank_reg_rd, bank_reg_num, push,
     pop, alu_op, alu_carry, alu_nibble, alu_sovf, alu_product, alu_div_zero, acc_in, acc_we, xmov_rd, xmov_wr,
     xmov_ptr16, xmov_to_flash, cmov_rd, code_addr} = '0;
  end
endmodule
`default_nettype wire

// file: testbench/mmap_core_mem_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mmap_core_mem_bench
  import mmap_pkg::*;
;
  logic sys_clk;
  logic rst;
  int   n_mismatch;
  int   checked;
  wire logic dir_rd, dir_wr, ind_rd, ind_wr, bit_op, ind_sel, wr_bit, bank_reg_rd, push, pop, acc_we;
  wire logic alu_carry, alu_nibble, alu_sovf, alu_div_zero, xmov_rd, xmov_wr, xmov_ptr16, xmov_to_flash, cmov_rd;
  wire logic [7:0] dir_addr, wr_data, acc_in;
  wire logic [2:0] bank_reg_num, alu_op;
  wire logic [15:0] alu_product, code_addr;
  logic [7:0] rd_data, status_word, acc, stack_ptr, flash_wdata;
  logic [15:0] data_ptr, flash_addr;
  logic [3:0] xram_page;
  logic rd_bit, rd_valid, flash_rd, flash_wr, flash_reserved;

  mmap_core_mem uut (
    .SYS_CLK(sys_clk), .RST(rst), .DIR_RD(dir_rd), .DIR_WR(dir_wr), .IND_RD(ind_rd), .IND_WR(ind_wr),
    .BIT_OP(bit_op), .DIR_ADDR(dir_addr), .IND_SEL(ind_sel), .WR_DATA(wr_data), .WR_BIT(wr_bit),
    .BANK_REG_RD(bank_reg_rd), .BANK_REG_NUM(bank_reg_num), .PUSH(push), .POP(pop), .ALU_OP(alu_op),
    .ALU_CARRY(alu_carry), .ALU_NIBBLE(alu_nibble), .ALU_SOVF(alu_sovf), .ALU_PRODUCT(alu_product),
    .ALU_DIV_ZERO(alu_div_zero), .ACC_IN(acc_in), .ACC_WE(acc_we), .XMOV_RD(xmov_rd), .XMOV_WR(xmov_wr),
    .XMOV_PTR16(xmov_ptr16), .XMOV_TO_FLASH(xmov_to_flash), .CMOV_RD(cmov_rd), .CODE_ADDR(code_addr),
    .RD_DATA(rd_data), .RD_BIT(rd_bit), .RD_VALID(rd_valid), .STATUS_WORD(status_word), .ACC(acc),
    .STACK_PTR(stack_ptr), .DATA_PTR(data_ptr), .XRAM_PAGE(xram_page), .FLASH_ADDR(flash_addr),
    .FLASH_RD(flash_rd), .FLASH_WR(flash_wr), .FLASH_WDATA(flash_wdata), .FLASH_RESERVED(flash_reserved)
  );
  mmap_exec_model exu (
    .sys_clk(sys_clk), .dir_rd(dir_rd), .dir_wr(dir_wr), .ind_rd(ind_rd), .ind_wr(ind_wr), .bit_op(bit_op),
    .dir_addr(dir_addr), .ind_sel(ind_sel), .wr_data(wr_data), .wr_bit(wr_bit), .bank_reg_rd(bank_reg_rd),
    .bank_reg_num(bank_reg_num), .push(push), .pop(pop), .alu_op(alu_op), .alu_carry(alu_carry),
    .alu_nibble(alu_nibble), .alu_sovf(alu_sovf), .alu_product(alu_product), .alu_div_zero(alu_div_zero),
    .acc_in(acc_in), .acc_we(acc_we), .xmov_rd(xmov_rd), .xmov_wr(xmov_wr), .xmov_ptr16(xmov_ptr16),
    .xmov_to_flash(xmov_to_flash), .cmov_rd(cmov_rd), .code_addr(code_addr)
  );

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, e, got);
    end
  endtask
  // read answers are only valid in the cycle after the request
  task automatic rd(input string what, input logic [7:0] e);
    chk(what, {8'h01, e}, {7'h00, rd_valid, rd_data});
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk("status", STATUS_RESET, status_word);
    chk("stack", STACK_RESET, stack_ptr);
    chk("ptr page acc", 16'h0000, data_ptr | {4'h0, xram_page, acc});
    exu.dir(1'b1, 1'b0, 1'b0, SFR_STATUS_ADDR, 8'h00, 1'b0);
    rd("status read", 8'h00);
  endtask
  task automatic t_stack();
    exu.stk(1'b1, 1'b0, 8'hA5);
    chk("stack", 8'h08, stack_ptr);
    exu.dir(1'b1, 1'b0, 1'b0, 8'h08, 8'h00, 1'b0);
    rd("stack top", 8'hA5);
    exu.stk(1'b1, 1'b0, 8'hC3);
    exu.stk(1'b0, 1'b1, 8'h00);
    rd("pop", 8'hC3);
    chk("stack", 8'h08, stack_ptr);
  endtask
  task automatic t_alu();
    // the other class follows an add so that its nibble clear and held overflow both show
    logic [2:0]  op [8] = '{MMAP_ALU_ADD, MMAP_ALU_OTHER, MMAP_ALU_ADDC, MMAP_ALU_SUBB, MMAP_ALU_MUL, MMAP_ALU_MUL,
                            MMAP_ALU_DIV, MMAP_ALU_DIV};
    logic [3:0]  f [8]  = '{4'hE, 4'h4, 4'h4, 4'hA, 4'h8, 4'h8, 4'h9, 4'h0};
    logic [15:0] p [8]  = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0100, 16'h00FF, 16'h0, 16'h0};
    logic [2:0]  e [8]  = '{3'h7, 3'h1, 3'h2, 3'h5, 3'h1, 3'h0, 3'h1, 3'h0};
    for (int i = 0; i < 8; i++) begin
      exu.alu(op[i], f[i], p[i]);
      chk("flags", {13'h0, e[i]}, {13'h0, status_word[7], status_word[6], status_word[2]});
    end
  endtask
  task automatic t_status();
    exu.dir(1'b0, 1'b1, 1'b0, SFR_STATUS_ADDR, 8'hFF, 1'b0);
    chk("status", 8'hFE, status_word);
    exu.dir(1'b0, 1'b1, 1'b0, SFR_STATUS_ADDR, 8'h22, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b1, 8'hD5, 8'h00, 1'b0);
    exu.dir(1'b1, 1'b0, 1'b0, SFR_STATUS_ADDR, 8'h00, 1'b0);
    rd("status read", 8'h02);
    exu.dir(1'b1, 1'b0, 1'b1, 8'hD1, 8'h00, 1'b0);
    chk("flag bit", 16'h3, {14'h0, rd_valid, rd_bit});
  endtask
  task automatic t_banks();
    for (int k = 0; k < 4; k++) begin
      exu.dir(1'b0, 1'b1, 1'b0, SFR_STATUS_ADDR, {3'h0, 2'(k), 3'h0}, 1'b0);
      exu.dir(1'b0, 1'b1, 1'b0, {3'h0, 2'(k), 3'h2}, 8'(k + 64), 1'b0);
      exu.breg(3'h2);
      rd("bank reg", 8'(k + 64));
    end
  endtask
  task automatic t_indirect();
    exu.dir(1'b0, 1'b1, 1'b0, SFR_STATUS_ADDR, 8'h08, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b0, 8'h08, 8'h90, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b0, 8'h09, 8'h30, 1'b0);
    exu.ind(1'b0, 1'b1, 1'b0, 8'h5A);
    exu.ind(1'b0, 1'b1, 1'b1, 8'h6B);
    exu.ind(1'b1, 1'b0, 1'b0, 8'h00);
    rd("upper ram", 8'h5A);
    exu.dir(1'b1, 1'b0, 1'b0, 8'h30, 8'h00, 1'b0);
    rd("lower ram", 8'h6B);
    exu.dir(1'b1, 1'b0, 1'b0, 8'h90, 8'h00, 1'b0);
    rd("register space", 8'h00);
  endtask
  task automatic t_bits();
    exu.dir(1'b0, 1'b1, 1'b0, 8'h22, 8'h81, 1'b0);
    exu.go();
    exu.dir(1'b1, 1'b0, 1'b1, 8'h13, 8'h00, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b1, 8'h13, 8'h00, 1'b1);
    exu.dir(1'b1, 1'b0, 1'b0, 8'h22, 8'h00, 1'b0);
    rd("bit area byte", 8'h89);
    exu.dir(1'b1, 1'b0, 1'b1, 8'h17, 8'h00, 1'b0);
    chk("bit read", 16'h3, {14'h0, rd_valid, rd_bit});
  endtask
  task automatic t_xram();
    exu.dir(1'b0, 1'b1, 1'b0, SFR_STATUS_ADDR, 8'h00, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b0, SFR_PAGE_ADDR, 8'hF3, 1'b0);
    chk("page", 16'h3, {12'h0, xram_page});
    exu.dir(1'b1, 1'b0, 1'b0, SFR_PAGE_ADDR, 8'h00, 1'b0);
    rd("page read", 8'h03);
    exu.dir(1'b0, 1'b1, 1'b0, 8'h00, 8'h45, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b0, 8'h01, 8'h45, 1'b0);
    exu.xmov(1'b0, 1'b1, 1'b0, 1'b0, 8'h77);
    chk("flash write", 16'h0, {15'h0, flash_wr});
    exu.dir(1'b0, 1'b1, 1'b0, SFR_DPH_ADDR, 8'h03, 1'b0);
    exu.dir(1'b0, 1'b1, 1'b0, SFR_DPL_ADDR, 8'h45, 1'b0);
    chk("data pointer", 16'h0345, data_ptr);
    exu.xmov(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    rd("xram", 8'h77);
    exu.xmov(1'b0, 1'b1, 1'b1, 1'b1, 8'h3C);
    chk("flash write", 16'h013C, {7'h0, flash_wr, flash_wdata});
  endtask
  task automatic t_flash();
    exu.cmov(FLASH_END_LARGE);
    chk("flash read", 16'h2, {14'h0, flash_rd, flash_reserved});
    chk("flash addr", FLASH_END_LARGE, flash_addr);
    exu.cmov(16'hFC00);
    chk("flash read", 16'h3, {14'h0, flash_rd, flash_reserved});
  endtask
  task automatic t_parity();
    exu.acc(8'h07);
    chk("parity", 16'h0107, {7'h0, status_word[0], acc});
    exu.acc(8'h03);
    chk("parity", 16'h0003, {7'h0, status_word[0], acc});
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    n_mismatch = 0;
    checked = 0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_stack();
    t_alu();
    t_status();
    t_banks();
    t_indirect();
    t_bits();
    t_xram();
    t_flash();
    t_parity();
    tally_and_finish();
  end
  // bound on the whole run; a hang counts as a mismatch
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
